// ===== hw/dnpo_outstation.sv
// outstation protocol handler: link, transport and application decode with responses
`timescale 1ns/1ps
`default_nettype none
// Operation
// - responses go out with direction zero and primary one
// - link acknowledgments go out with direction and primary both zero
// - confirmed link traffic refused until a link reset command arrives
// - unconfirmed user data is always processed
// - confirmed user data to this station is acknowledged before it is processed
// - any reply to user data goes out as unconfirmed user data
// - station address 0 to 247 selects this outstation
// - destination 65535 is accepted as all stations
// - transport segment must carry first and final flags
// - application fragment must carry first and final flags
// - application confirmation never requested nor awaited
// - read supported for binary outputs, counters, analog inputs, class data
// - variation 0 read answered with each group's fixed variation
// - write accepted only for internal indications
// - direct operate accepted for relay output block variation 1
// - direct operate without reply switches to modbus, no reply sent
// - every application reply uses response function 129
// - binary output point 0 reads one while energy clears
// - binary output point 1 reads one unless switched to modbus
// - modbus switch is temporary, cleared only by device reset
// - energy reset needs pulse on, count one, 1 ms on, 0 ms off
// - link characters are 8 data bits, no parity, 1 stop bit
module dnpo_outstation #(
    parameter int CLEAR_CYCLES = dnpo_pkg::CLEAR_CYC
) (
    input wire logic REF_CLK,
    input wire logic RESET,
    input wire logic [7:0] STATION_ADDR,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_BYTE,
    input wire logic RX_FIRST,
    input wire logic RX_LAST,
    input wire logic TX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_BYTE,
    output logic TX_LAST,
    output logic ENERGY_CLEAR,
    output logic MODBUS_MODE,
    output logic LINK_READY
);
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK = 2'b01,
        ST_EXEC = 2'b10,
        ST_RSP = 2'b11
    } dnpo_state_t;

    localparam logic [23:0] CLEAR_LOAD = 24'(CLEAR_CYCLES);

    logic rx_done;
    logic [7:0] rx_len;
    logic [dnpo_pkg::RX_DEPTH-1:0][7:0] rx_b;
    logic tx_busy;

    dnpo_state_t st_q, st_d;
    logic link_reset_q, link_reset_d, clear_q, clear_d, modbus_q, modbus_d, restart_q, restart_d;
    logic start_q, start_d;
    logic [23:0] clear_cnt_q, clear_cnt_d;
    dnpo_pkg::dnpo_tx_t desc_q, desc_d;
    // decoded action held across the acknowledgment
    logic act_reply_q, act_reply_d, act_write_q, act_write_d;
    logic act_clear_q, act_clear_d, act_modbus_q, act_modbus_d;

    dnpo_rx_capture #(.DEPTH(dnpo_pkg::RX_DEPTH)) u_rx (
        .clk(REF_CLK),
        .rst(RESET),
        .in_valid(RX_VALID),
        .in_byte(RX_BYTE),
        .in_first(RX_FIRST),
        .in_last(RX_LAST),
        .done(rx_done),
        .len(rx_len),
        .bytes(rx_b)
    );

    dnpo_tx_serial u_tx (
        .clk(REF_CLK),
        .rst(RESET),
        .start(start_q),
        .desc(desc_q),
        .busy(tx_busy),
        .tx_valid(TX_VALID),
        .tx_byte(TX_BYTE),
        .tx_last(TX_LAST),
        .tx_ready(TX_READY)
    );

    // fixed variation per readable group; zero marks an unreadable group
    function automatic logic [7:0] fixed_var(input logic [7:0] grp);
        case (grp)
            dnpo_pkg::GRP_BOUT: fixed_var = dnpo_pkg::VAR_BOUT;
            dnpo_pkg::GRP_CNT: fixed_var = dnpo_pkg::VAR_CNT;
            dnpo_pkg::GRP_AIN: fixed_var = dnpo_pkg::VAR_AIN;
            dnpo_pkg::GRP_CLASS: fixed_var = dnpo_pkg::VAR_CLASS;
            default: fixed_var = 8'h00;
        endcase
    endfunction

    logic [7:0] ctrl, afn, grp, vari;
    logic [15:0] dst;
    logic own_hit, all_hit, prm_ok, lfn_reset, lfn_conf, lfn_unconf, seg_ok, user_ok;
    logic read_ok, write_ok, op_ok, opna_ok, crob_ok;
    logic [31:0] on_ms, off_ms;

    always_comb begin
        ctrl = rx_b[dnpo_pkg::OFF_CTRL];
        dst = {rx_b[dnpo_pkg::OFF_DST_HI], rx_b[dnpo_pkg::OFF_DST_LO]};
        afn = rx_b[dnpo_pkg::OFF_AFN];
        grp = rx_b[dnpo_pkg::OFF_GRP];
        vari = rx_b[dnpo_pkg::OFF_VAR];
        on_ms = {rx_b[dnpo_pkg::OFF_ON+3], rx_b[dnpo_pkg::OFF_ON+2], rx_b[dnpo_pkg::OFF_ON+1], rx_b[dnpo_pkg::OFF_ON]};
        off_ms = {rx_b[dnpo_pkg::OFF_OFF+3], rx_b[dnpo_pkg::OFF_OFF+2], rx_b[dnpo_pkg::OFF_OFF+1],
                  rx_b[dnpo_pkg::OFF_OFF]};
        // an out-of-range programmed address never matches
        own_hit = (STATION_ADDR <= dnpo_pkg::ADDR_MAX) && (dst == {8'h00, STATION_ADDR});
        all_hit = dst == dnpo_pkg::ADDR_ALL;
        prm_ok = ctrl[dnpo_pkg::CTL_DIR] && ctrl[dnpo_pkg::CTL_PRM] && (rx_len >= dnpo_pkg::LEN_LINK);
        lfn_reset = prm_ok && (ctrl[3:0] == dnpo_pkg::LFN_RESET_LINK);
        lfn_conf = prm_ok && (ctrl[3:0] == dnpo_pkg::LFN_USER_CONF) && link_reset_q;
        lfn_unconf = prm_ok && (ctrl[3:0] == dnpo_pkg::LFN_USER_UNCONF);
        seg_ok = (rx_len >= dnpo_pkg::LEN_APP)
            && rx_b[dnpo_pkg::OFF_TP][dnpo_pkg::TP_FIR] && rx_b[dnpo_pkg::OFF_TP][dnpo_pkg::TP_FIN]
            && rx_b[dnpo_pkg::OFF_AC][dnpo_pkg::AC_FIR] && rx_b[dnpo_pkg::OFF_AC][dnpo_pkg::AC_FIN];
        user_ok = (lfn_conf || lfn_unconf) && seg_ok && (own_hit || all_hit);
        crob_ok = user_ok && (rx_len >= dnpo_pkg::LEN_CROB) && (grp == dnpo_pkg::GRP_CROB)
            && (vari == dnpo_pkg::VAR_CROB);
        read_ok = user_ok && (afn == dnpo_pkg::AFN_READ) && (rx_len >= dnpo_pkg::LEN_OBJ)
            && (fixed_var(grp) != 8'h00) && ((vari == dnpo_pkg::VAR_ANY) || (vari == fixed_var(grp)));
        write_ok = user_ok && (afn == dnpo_pkg::AFN_WRITE) && (rx_len >= dnpo_pkg::LEN_OBJ)
            && (grp == dnpo_pkg::GRP_IIN) && (vari == dnpo_pkg::VAR_IIN);
        op_ok = crob_ok && (afn == dnpo_pkg::AFN_DIR_OP) && (rx_b[dnpo_pkg::OFF_IDX] == dnpo_pkg::IDX_ENERGY)
            && (rx_b[dnpo_pkg::OFF_CODE] == dnpo_pkg::CODE_PULSE_ON) && (rx_b[dnpo_pkg::OFF_CNT] == dnpo_pkg::CROB_COUNT)
            && (on_ms == dnpo_pkg::CROB_ON_MS) && (off_ms == dnpo_pkg::CROB_OFF_MS);
        opna_ok = crob_ok && (afn == dnpo_pkg::AFN_DIR_OP_NA) && (rx_b[dnpo_pkg::OFF_IDX] == dnpo_pkg::IDX_PROTO);
    end

    always_comb begin
        st_d = st_q;
        link_reset_d = link_reset_q;
        clear_d = clear_q;
        clear_cnt_d = clear_cnt_q;
        modbus_d = modbus_q;
        restart_d = restart_q;
        start_d = 1'b0;
        desc_d = desc_q;
        act_reply_d = act_reply_q;
        act_write_d = act_write_q;
        act_clear_d = act_clear_q;
        act_modbus_d = act_modbus_q;
        if (clear_q) begin
            clear_cnt_d = clear_cnt_q - 24'h000001;
            if (clear_cnt_q == 24'h000001) begin
                clear_d = 1'b0;
            end
        end
        case (st_q)
            // frames that land outside idle are dropped: the link is half duplex
            ST_IDLE: begin
                if (rx_done) begin
                    act_reply_d = (read_ok || write_ok || op_ok) && !all_hit;
                    act_write_d = write_ok;
                    act_clear_d = op_ok;
                    act_modbus_d = opna_ok;
                    desc_d.dst = {rx_b[dnpo_pkg::OFF_SRC_HI], rx_b[dnpo_pkg::OFF_SRC_LO]};
                    desc_d.src = STATION_ADDR;
                    desc_d.seq = rx_b[dnpo_pkg::OFF_AC][3:0];
                    desc_d.has_obj = read_ok || op_ok;
                    desc_d.grp = grp;
                    desc_d.vari = read_ok ? fixed_var(grp) : vari;
                    if (own_hit && (lfn_reset || lfn_conf)) begin
                        link_reset_d = link_reset_q || lfn_reset;
                        desc_d.rsp = 1'b0;
                        start_d = 1'b1;
                        st_d = lfn_reset ? ST_RSP : ST_ACK;
                    end else if (user_ok) begin
                        st_d = ST_EXEC;
                    end
                end
            end
            ST_ACK: begin
                if (!start_q && !tx_busy) begin
                    st_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (act_write_q) begin
                    restart_d = 1'b0;
                end
                if (act_clear_q) begin
                    clear_d = 1'b1;
                    clear_cnt_d = CLEAR_LOAD;
                end
                if (act_modbus_q) begin
                    modbus_d = 1'b1;
                end
                desc_d.iin = {8'h00, 1'(act_write_q ? 1'b0 : restart_q), 7'h00};
                desc_d.data = {6'h00, ~modbus_q, clear_q || act_clear_q};
                if (act_reply_q) begin
                    desc_d.rsp = 1'b1;
                    start_d = 1'b1;
                    st_d = ST_RSP;
                end else begin
                    st_d = ST_IDLE;
                end
            end
            ST_RSP: begin
                if (!start_q && !tx_busy) begin
                    st_d = ST_IDLE;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            st_q <= ST_IDLE;
            link_reset_q <= 1'b0;
            clear_q <= 1'b0;
            clear_cnt_q <= 24'h000000;
            modbus_q <= 1'b0;
            restart_q <= 1'b1;
            start_q <= 1'b0;
            desc_q <= '0;
            act_reply_q <= 1'b0;
            act_write_q <= 1'b0;
            act_clear_q <= 1'b0;
            act_modbus_q <= 1'b0;
        end else begin
            st_q <= st_d;
            link_reset_q <= link_reset_d;
            clear_q <= clear_d;
            clear_cnt_q <= clear_cnt_d;
            modbus_q <= modbus_d;
            restart_q <= restart_d;
            start_q <= start_d;
            desc_q <= desc_d;
            act_reply_q <= act_reply_d;
            act_write_q <= act_write_d;
            act_clear_q <= act_clear_d;
            act_modbus_q <= act_modbus_d;
        end
    end

    assign ENERGY_CLEAR = clear_q;
    assign MODBUS_MODE = modbus_q;
    assign LINK_READY = link_reset_q;

    rsp_ctrl_byte_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q && desc_q.rsp |=> TX_BYTE == dnpo_pkg::CTRL_RSP)
        else $error("response control byte wrong");
    ack_ctrl_byte_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q && !desc_q.rsp |=> TX_BYTE == dnpo_pkg::CTRL_ACK && TX_VALID)
        else $error("ack control byte wrong");
    ack_needs_reset_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q && !desc_q.rsp |-> link_reset_q)
        else $error("ack sent before link reset");
    ack_before_work_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_q == ST_ACK |-> !modbus_d || modbus_q)
        else $error("request processed before ack finished");
    clear_cause_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(clear_q) |-> $past(st_q) == ST_EXEC && clear_cnt_q == CLEAR_LOAD)
        else $error("energy clear started without valid operate");
    clear_end_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        $fell(clear_q) |-> $past(clear_cnt_q) == 24'h000001)
        else $error("energy clear ended early");
    modbus_sticky_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        modbus_q |=> modbus_q)
        else $error("modbus switch dropped without reset");
    modbus_silent_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        $rose(modbus_q) && !$past(act_reply_q) |-> st_q == ST_IDLE && !start_q)
        else $error("reply sent after protocol switch");
    foreign_drop_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        rx_done && st_q == ST_IDLE && !own_hit && !all_hit |=> st_q == ST_IDLE && !start_q)
        else $error("foreign frame not dropped");
    link_gate_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_q == ST_ACK |-> link_reset_q)
        else $error("ack state entered before link reset");
    reply_unconf_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        st_q == ST_EXEC && act_reply_q |=> start_q && desc_q.rsp)
        else $error("reply not sent as user data");
    station_range_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q |-> STATION_ADDR <= dnpo_pkg::ADDR_MAX)
        else $error("frame sent with out-of-range address");
    bcast_quiet_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        rx_done && st_q == ST_IDLE && all_hit |=> !start_q ##1 !start_q)
        else $error("all-stations frame answered");
    fixed_var_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q && desc_q.rsp && desc_q.has_obj |-> desc_q.vari != dnpo_pkg::VAR_ANY)
        else $error("reply carries variation zero");
    clear_point_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q && desc_q.rsp && desc_q.has_obj && !act_clear_q |-> desc_q.data[0] == $past(clear_q))
        else $error("energy clear point wrong");
    switch_point_a: assert property (@(posedge REF_CLK) disable iff (RESET)
        start_q && desc_q.rsp && desc_q.has_obj |-> desc_q.data[1] == !$past(modbus_q))
        else $error("protocol switch point wrong");
endmodule // dnpo_outstation
`default_nettype wire

// ===== hw/dnpo_pkg.sv
// shared constants and carrier types of the dnp outstation protocol handler
package dnpo_pkg;
    // link control byte layout
    localparam int CTL_DIR = 7;
    localparam int CTL_PRM = 6;
    localparam logic [3:0] LFN_RESET_LINK = 4'h0;
    localparam logic [3:0] LFN_USER_CONF = 4'h3;
    localparam logic [3:0] LFN_USER_UNCONF = 4'h4;
    localparam logic [7:0] CTRL_ACK = 8'h00;
    localparam logic [7:0] CTRL_RSP = 8'h44;
    // transport and application control bits
    localparam int TP_FIN = 7;
    localparam int TP_FIR = 6;
    localparam int AC_FIR = 7;
    localparam int AC_FIN = 6;
    localparam logic [7:0] SEG_FIR_FIN = 8'hc0;
    // byte positions inside a captured frame (crc already stripped)
    localparam int OFF_CTRL = 0;
    localparam int OFF_DST_LO = 1;
    localparam int OFF_DST_HI = 2;
    localparam int OFF_SRC_LO = 3;
    localparam int OFF_SRC_HI = 4;
    localparam int OFF_TP = 5;
    localparam int OFF_AC = 6;
    localparam int OFF_AFN = 7;
    localparam int OFF_GRP = 8;
    localparam int OFF_VAR = 9;
    localparam int OFF_IDX = 12;
    localparam int OFF_CODE = 13;
    localparam int OFF_CNT = 14;
    localparam int OFF_ON = 15;
    localparam int OFF_OFF = 19;
    localparam int RX_DEPTH = 24;
    localparam logic [7:0] LEN_LINK = 8'h05;
    localparam logic [7:0] LEN_APP = 8'h08;
    localparam logic [7:0] LEN_OBJ = 8'h0a;
    localparam logic [7:0] LEN_CROB = 8'h17;
    // application function codes and objects
    localparam logic [7:0] AFN_READ = 8'h01;
    localparam logic [7:0] AFN_WRITE = 8'h02;
    localparam logic [7:0] AFN_DIR_OP = 8'h05;
    localparam logic [7:0] AFN_DIR_OP_NA = 8'h06;
    localparam logic [7:0] AFN_RESPONSE = 8'h81;
    localparam logic [7:0] GRP_BOUT = 8'h0a;
    localparam logic [7:0] GRP_CROB = 8'h0c;
    localparam logic [7:0] GRP_CNT = 8'h14;
    localparam logic [7:0] GRP_AIN = 8'h1e;
    localparam logic [7:0] GRP_CLASS = 8'h3c;
    localparam logic [7:0] GRP_IIN = 8'h50;
    localparam logic [7:0] VAR_ANY = 8'h00;
    localparam logic [7:0] VAR_BOUT = 8'h02;
    localparam logic [7:0] VAR_CNT = 8'h05;
    localparam logic [7:0] VAR_AIN = 8'h04;
    localparam logic [7:0] VAR_CLASS = 8'h01;
    localparam logic [7:0] VAR_CROB = 8'h01;
    localparam logic [7:0] VAR_IIN = 8'h01;
    localparam logic [7:0] IDX_ENERGY = 8'h00;
    localparam logic [7:0] IDX_PROTO = 8'h01;
    localparam logic [7:0] CODE_PULSE_ON = 8'h01;
    localparam logic [7:0] CROB_COUNT = 8'h01;
    localparam logic [31:0] CROB_ON_MS = 32'h00000001;
    localparam logic [31:0] CROB_OFF_MS = 32'h00000000;
    // response object header: qualifier 0x00, points 0..1
    localparam logic [7:0] QUAL_RANGE8 = 8'h00;
    localparam logic [7:0] RANGE_START = 8'h00;
    localparam logic [7:0] RANGE_STOP = 8'h01;
    localparam int IIN_RESTART = 7;
    // station addressing
    localparam logic [7:0] ADDR_MAX = 8'hf7;
    localparam logic [15:0] ADDR_ALL = 16'hffff;
    // frame lengths sent
    localparam logic [4:0] TXLEN_ACK = 5'h05;
    localparam logic [4:0] TXLEN_RSP = 5'h0a;
    localparam logic [4:0] TXLEN_OBJ = 5'h10;
    // timing
    localparam int CLK_HZ = 10_000_000;
    localparam int ON_TIME_MS = 1;
    localparam int CLEAR_CYC = CLK_HZ / 1000 * ON_TIME_MS;

    typedef struct packed {
        logic rsp;
        logic has_obj;
        logic [15:0] dst;
        logic [7:0] src;
        logic [3:0] seq;
        logic [15:0] iin;
        logic [7:0] grp;
        logic [7:0] vari;
        logic [7:0] data;
    } dnpo_tx_t;
endpackage

// ===== hw/dnpo_rx_capture.sv
// captures one de-framed link frame into a byte array
`timescale 1ns/1ps
`default_nettype none
module dnpo_rx_capture #(
    parameter int DEPTH = dnpo_pkg::RX_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [7:0] in_byte,
    input wire logic in_first,
    input wire logic in_last,
    output logic done,
    output logic [7:0] len,
    output logic [DEPTH-1:0][7:0] bytes
);
    logic [7:0] idx_q, idx_d, len_q, len_d;
    logic done_q, done_d;
    logic [DEPTH-1:0][7:0] mem_q, mem_d;
    logic [7:0] pos;

    always_comb begin
        mem_d = mem_q;
        idx_d = idx_q;
        len_d = len_q;
        done_d = 1'b0;
        pos = in_first ? 8'h00 : idx_q;
        if (in_valid) begin
            // bytes past the array are counted but dropped; length still tells the truth
            if (pos < 8'(DEPTH)) begin
                mem_d[pos[$clog2(DEPTH)-1:0]] = in_byte;
            end
            idx_d = pos + 8'h01;
            if (in_last) begin
                done_d = 1'b1;
                len_d = pos + 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_q <= '0;
            idx_q <= 8'h00;
            len_q <= 8'h00;
            done_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            idx_q <= idx_d;
            len_q <= len_d;
            done_q <= done_d;
        end
    end

    assign done = done_q;
    assign len = len_q;
    assign bytes = mem_q;
endmodule // dnpo_rx_capture
`default_nettype wire

// ===== hw/dnpo_tx_serial.sv
// serialises an acknowledgment or response frame byte by byte
`timescale 1ns/1ps
`default_nettype none
module dnpo_tx_serial (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire dnpo_pkg::dnpo_tx_t desc,
    output logic busy,
    output logic tx_valid,
    output logic [7:0] tx_byte,
    output logic tx_last,
    input wire logic tx_ready
);
    dnpo_pkg::dnpo_tx_t desc_q, desc_d;
    logic [4:0] idx_q, idx_d;
    logic busy_q, busy_d, valid_q, valid_d, last_q, last_d;
    logic [7:0] byte_q, byte_d;

    function automatic logic [4:0] frame_len(input dnpo_pkg::dnpo_tx_t d);
        if (!d.rsp) begin
            frame_len = dnpo_pkg::TXLEN_ACK;
        end else if (d.has_obj) begin
            frame_len = dnpo_pkg::TXLEN_OBJ;
        end else begin
            frame_len = dnpo_pkg::TXLEN_RSP;
        end
    endfunction

    function automatic logic [7:0] byte_at(input dnpo_pkg::dnpo_tx_t d, input logic [4:0] i);
        case (i)
            5'h00: byte_at = d.rsp ? dnpo_pkg::CTRL_RSP : dnpo_pkg::CTRL_ACK;
            5'h01: byte_at = d.dst[7:0];
            5'h02: byte_at = d.dst[15:8];
            5'h03: byte_at = d.src;
            5'h04: byte_at = 8'h00;
            5'h05: byte_at = dnpo_pkg::SEG_FIR_FIN | {4'h0, d.seq};
            // con bit stays clear: no application confirmation is ever requested
            5'h06: byte_at = dnpo_pkg::SEG_FIR_FIN | {4'h0, d.seq};
            5'h07: byte_at = dnpo_pkg::AFN_RESPONSE;
            5'h08: byte_at = d.iin[7:0];
            5'h09: byte_at = d.iin[15:8];
            5'h0a: byte_at = d.grp;
            5'h0b: byte_at = d.vari;
            5'h0c: byte_at = dnpo_pkg::QUAL_RANGE8;
            5'h0d: byte_at = dnpo_pkg::RANGE_START;
            5'h0e: byte_at = dnpo_pkg::RANGE_STOP;
            5'h0f: byte_at = d.data;
            default: byte_at = 8'h00;
        endcase
    endfunction

    always_comb begin
        desc_d = desc_q;
        idx_d = idx_q;
        busy_d = busy_q;
        valid_d = valid_q;
        last_d = last_q;
        byte_d = byte_q;
        if (start && !busy_q) begin
            desc_d = desc;
            idx_d = 5'h00;
            busy_d = 1'b1;
            valid_d = 1'b1;
            byte_d = byte_at(desc, 5'h00);
            last_d = 1'b0;
        end else if (valid_q && tx_ready) begin
            if (last_q) begin
                valid_d = 1'b0;
                busy_d = 1'b0;
                last_d = 1'b0;
            end else begin
                idx_d = idx_q + 5'h01;
                byte_d = byte_at(desc_q, idx_q + 5'h01);
                last_d = (idx_q + 5'h02) == frame_len(desc_q);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            desc_q <= '0;
            idx_q <= 5'h00;
            busy_q <= 1'b0;
            valid_q <= 1'b0;
            last_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            desc_q <= desc_d;
            idx_q <= idx_d;
            busy_q <= busy_d;
            valid_q <= valid_d;
            last_q <= last_d;
            byte_q <= byte_d;
        end
    end

    assign busy = busy_q;
    assign tx_valid = valid_q;
    assign tx_byte = byte_q;
    assign tx_last = last_q;
endmodule // dnpo_tx_serial
`default_nettype wire

// ===== testbench/dnpo_master_model.sv
// master station model: sends request frames, collects outstation bytes
`timescale 1ns/1ps
`default_nettype none
module dnpo_master_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic rx_first,
    output logic rx_last,
    output logic tx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_byte,
    input wire logic tx_last
);
    logic [7:0] got [$];
    int ends [$];
    logic slow = 1'b0;
    initial begin
        {rx_valid, rx_first, rx_last, tx_ready} = 4'h0;
        rx_byte = 8'h00;
    end
    // whole characters of 8 bits, crc stripped upstream
    task automatic send(input logic [7:0] f [0:22], input int n);
        got.delete();
        ends.delete();
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= f[i];
            rx_first <= (i == 0);
            rx_last <= (i == n - 1);
        end
        @(posedge clk);
        {rx_valid, rx_first, rx_last} <= 3'h0;
        // released line shows the inverse, not a stale byte
        rx_byte <= ~f[n-1];
    endtask
    always @(posedge clk) begin
        if (tx_valid && tx_ready) begin
            if (tx_last)
                ends.push_back(got.size());
            got.push_back(tx_byte);
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end
endmodule // dnpo_master_model
`default_nettype wire

// ===== testbench/test_dnpo_outstation.sv
// self-checking bench of the outstation protocol handler
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin num_errors++; $display("BAD %s exp %0h got %0h", n, e, a); end end
module test_dnpo_outstation;
    localparam int CLR = 20;
    logic clk = 0;
    logic rst = 1;
    logic rx_v, rx_f, rx_l, tx_r, tx_v, tx_l, e_clr, mb, lrdy;
    logic [7:0] rx_b, tx_b;
    logic [7:0] sa = 8'hf7;
    logic [7:0] f [0:22];
    logic [7:0] grp [0:2] = '{8'h14, 8'h1e, 8'h3c};
    logic [7:0] vr [0:2] = '{8'h05, 8'h04, 8'h01};
    int num_errors = 0;
    int checks = 0;
    int cyc = 0;
    int hi = 0;
    initial forever #50 clk = ~clk;
    dnpo_outstation #(.CLEAR_CYCLES(CLR)) dut_u (.REF_CLK(clk), .RESET(rst), .STATION_ADDR(sa), .RX_VALID(rx_v),
        .RX_BYTE(rx_b), .RX_FIRST(rx_f), .RX_LAST(rx_l), .TX_READY(tx_r), .TX_VALID(tx_v), .TX_BYTE(tx_b),
        .TX_LAST(tx_l), .ENERGY_CLEAR(e_clr), .MODBUS_MODE(mb), .LINK_READY(lrdy));
    dnpo_master_model mst_u (.clk(clk), .rx_valid(rx_v), .rx_byte(rx_b), .rx_first(rx_f), .rx_last(rx_l),
        .tx_ready(tx_r), .tx_valid(tx_v), .tx_byte(tx_b), .tx_last(tx_l));
    task final_report;
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        hi <= hi + e_clr;
        if (cyc == 4000) begin
            num_errors++;
            final_report();
        end
    end
    task automatic go(input logic [7:0] c, input logic [15:0] d, input logic [7:0] fn, g, v, idx, on, input int n,
            input logic [7:0] tp = 8'hc0, ac = 8'hc3);
        f = '{c, d[7:0], d[15:8], 8'h01, 8'h00, tp, ac, fn, g, v, (n > 11) ? 8'h17 : 8'h06, 8'h01, idx, 8'h01,
            8'h01, on, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        mst_u.send(f, n);
        repeat (80) @(posedge clk);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        go(8'hc3, 16'h00f7, 8'h01, 8'h0a, 8'h00, 0, 0, 11);
        `CHK("early", 0, mst_u.got.size())
        go(8'hc4, 16'h00f7, 8'h01, 8'h0a, 8'h00, 0, 0, 11);
        `CHK("len", 16, mst_u.got.size())
        `CHK("ctrl", 8'h44, mst_u.got[0])
        `CHK("tp", 8'hc3, mst_u.got[5])
        `CHK("afn", 8'h81, mst_u.got[7])
        `CHK("var", 8'h02, mst_u.got[11])
        `CHK("iin", 8'h80, mst_u.got[8])
        `CHK("pts", 8'h02, mst_u.got[15])
        go(8'hc0, 16'h00f7, 0, 0, 0, 0, 0, 5);
        `CHK("ack len", 5, mst_u.got.size())
        `CHK("ack", 8'h00, mst_u.got[0])
        `CHK("ack end", 4, mst_u.ends[0])
        `CHK("linked", 1'b1, lrdy)
        // stalling sink while acks and replies go out back to back
        mst_u.slow = 1'b1;
        for (int i = 0; i < 3; i++) begin
            go(8'hc3, 16'h00f7, 8'h01, grp[i], 8'h00, 0, 0, 11);
            `CHK("conf len", 21, mst_u.got.size())
            `CHK("ack 1st", 8'h00, mst_u.got[0])
            `CHK("unconf", 8'h44, mst_u.got[5])
            `CHK("var", vr[i], mst_u.got[16])
            `CHK("rsp end", 20, mst_u.ends[1])
        end
        go(8'hc4, 16'h01f7, 8'h01, 8'h0a, 8'h00, 0, 0, 11);
        `CHK("addr", 0, mst_u.got.size())
        sa <= 8'hf8;
        go(8'hc4, 16'h00f8, 8'h01, 8'h0a, 8'h00, 0, 0, 11);
        `CHK("range", 0, mst_u.got.size())
        sa <= 8'hf7;
        go(8'hc4, 16'h00f7, 8'h01, 8'h14, 8'h01, 0, 0, 11);
        `CHK("bad var", 0, mst_u.got.size())
        go(8'hc4, 16'h00f7, 8'h01, 8'h0a, 8'h00, 0, 0, 11, 8'h80);
        `CHK("no fir", 0, mst_u.got.size())
        go(8'hc4, 16'h00f7, 8'h01, 8'h0a, 8'h00, 0, 0, 11, 8'hc0, 8'h83);
        `CHK("no fin", 0, mst_u.got.size())
        go(8'hc4, 16'h00f7, 8'h02, 8'h0a, 8'h02, 0, 0, 11);
        `CHK("write", 0, mst_u.got.size())
        go(8'hc4, 16'h00f7, 8'h02, 8'h50, 8'h01, 0, 0, 11);
        `CHK("wr len", 10, mst_u.got.size())
        `CHK("wr iin", 8'h00, mst_u.got[8])
        go(8'hc4, 16'h00f7, 8'h05, 8'h0c, 8'h01, 0, 8'h02, 23);
        `CHK("bad on", 0, hi)
        go(8'hc4, 16'h00f7, 8'h05, 8'h0c, 8'h01, 0, 8'h01, 23);
        `CHK("crob", 8'h0c, mst_u.got[10])
        `CHK("clr pt", 8'h03, mst_u.got[15])
        `CHK("clear", CLR, hi)
        go(8'hc4, 16'hffff, 8'h05, 8'h0c, 8'h01, 0, 8'h01, 23);
        `CHK("bcast", 2 * CLR, hi)
        `CHK("bc quiet", 0, mst_u.got.size())
        go(8'hc4, 16'h00f7, 8'h06, 8'h0c, 8'h01, 8'h01, 0, 23);
        `CHK("silent", 0, mst_u.got.size())
        `CHK("modbus", 1'b1, mb)
        go(8'hc4, 16'h00f7, 8'h01, 8'h0a, 8'h00, 0, 0, 11);
        `CHK("sw pt", 8'h00, mst_u.got[15])
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        `CHK("dnp", 1'b0, mb)
        final_report();
    end
endmodule // test_dnpo_outstation
`default_nettype wire
